// >>> src/bus_master_port.sv
// Master port: fundamental zero-latency reads on the system interconnect.
// Assumes the fabric end drives waitrequest and readdata on the same clock.
//
// Overview of operation
// RQ1: All transfers synchronous to one clock.
// RQ2: Address output carries a byte address.
// RQ3: Optional active-low byte lane selects.
// RQ4: Read strobe paired with read word input.
// RQ5: Write strobe paired with write word.
// RQ6: Stall input holds master waiting.
// RQ7: Fabric drives interrupt request and priority.
// RQ8: Packet end input from slave side.
// RQ9: Returned-word-valid input for latent reads.
// RQ10: Cancel output discards pending latent reads.
// RQ11: Strobes and lane selects are active low.
// RQ12: Address, lanes, strobe driven after edge.
// RQ13: Fabric raises stall before next edge.
// RQ14: Outputs held while stall sampled high.
// RQ15: Capture read word when stall low.
// RQ16: New transfer may follow without idle.
// RQ17: Read strobe may stay low between reads.
// RQ18: Transfer lasts stall cycles plus one.
// RQ19: Stall sampled on every transfer cycle.
// RQ20: Reset behaviour is this design's own.
// RQ21: All lane selects active during reads.
// RQ22: No time-out; stall as long as told.
// RQ23: Address, lanes and strobes are registered.
`timescale 1ns/1ps
`include "mport_defs.svh"

module bus_master_port #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic clk, // System clock
    input wire logic reset_n, // Synchronous reset
    mport_if.master bus, // Link to the fabric
    input wire logic [`ADDR_W-1:0] req_addr, // Byte address to read
    input wire logic req_valid, // Read request offered
    output logic req_ready, // Request taken this edge
    output logic [`DATA_W-1:0] rsp_data, // Returned word
    output logic rsp_valid, // Returned word valid
    input wire logic rsp_ready, // Consumer takes word
    output logic irq_pending, // Fabric interrupt seen
    output logic [`PRIO_W-1:0] irq_level, // Priority of interrupter
    output logic packet_end // Packet end flag seen
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int CREDIT_W = $clog2(FIFO_DEPTH) + 1;

    mport_pkg::mstate_t state;
    logic [`ADDR_W-1:0] addr_q;
    logic read_q;
    logic [CREDIT_W-1:0] credit;
    logic on_bus;
    logic have_room;
    logic done;
    logic take;
    logic pop;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Level on the wire of an active-low strobe [RQ11]
    function automatic logic strobe_level(input logic active);
        return !active;
    endfunction

    // Reads enable every lane; with no transfer all lanes are off
    function automatic logic [`LANES_W-1:0] lane_level(input logic active);
        return active ? `LANES_ALL_ON : `LANES_ALL_OFF;
    endfunction

    // ----------------------------------------------------------------
    // Request handshake
    // ----------------------------------------------------------------
    assign on_bus = (state == mport_pkg::M_BUSY);
    // A transfer ends on the first edge where stall is low [RQ15] [RQ19]
    assign done = on_bus && !bus.waitrequest;
    assign pop = rsp_valid && rsp_ready;
    // Room counts the word still on the bus as well: once stall drops the
    // fabric cannot be refused, so a word must never meet a full buffer
    assign have_room = (credit != CREDIT_W'(FIFO_DEPTH));
    assign take = req_valid && have_room && (!on_bus || done);
    assign req_ready = take; // [RQ16]

    // ----------------------------------------------------------------
    // Buffer credits
    // ----------------------------------------------------------------
    // Words buffered plus the one in flight; never above FIFO_DEPTH
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            credit <= '0;
        end else begin
            credit <= credit + CREDIT_W'(take) - CREDIT_W'(pop);
        end
    end

    // ----------------------------------------------------------------
    // Transfer state
    // ----------------------------------------------------------------
    // M_DONE marks the cycle after a transfer that had no successor;
    // outputs are idle there and a new request may start at once
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= mport_pkg::M_IDLE; // [RQ20]
        end else begin
            case (state)
                mport_pkg::M_IDLE: begin
                    if (take) begin
                        state <= mport_pkg::M_BUSY;
                    end
                end
                mport_pkg::M_BUSY: begin
                    // No time-out: stay as long as stall is held [RQ22] [RQ6]
                    if (done && !take) begin
                        state <= mport_pkg::M_DONE;
                    end
                end
                mport_pkg::M_DONE: begin
                    if (take) begin
                        state <= mport_pkg::M_BUSY;
                    end else begin
                        state <= mport_pkg::M_IDLE;
                    end
                end
                default: begin
                    state <= mport_pkg::M_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registered bus outputs [RQ23]
    // ----------------------------------------------------------------
    // Loaded when a request is taken and cleared when a transfer ends,
    // neither of which happens while stalled, so address and strobe hold through wait states [RQ14]
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            addr_q <= '0;
        end else if (take) begin
            addr_q <= req_addr; // [RQ2] [RQ12]
        end else if (done) begin
            addr_q <= '0; // [RQ15]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            read_q <= 1'b0;
        end else if (take) begin
            read_q <= 1'b1; // Stays active across back-to-back reads [RQ17]
        end else if (done) begin
            read_q <= 1'b0;
        end
    end

    assign bus.address = addr_q;
    assign bus.read_n = strobe_level(read_q); // [RQ4] [RQ11]
    assign bus.byteenable_n = lane_level(read_q); // [RQ21] [RQ3]
    assign bus.write_n = strobe_level(1'b0); // Read-only master [RQ5]
    assign bus.writedata = '0;
    assign bus.flush = 1'b0; // No latent reads issued [RQ10]

    // ----------------------------------------------------------------
    // Result buffer
    // ----------------------------------------------------------------
    // Credits guarantee room, so the buffer's own ready is not needed
    word_fifo #(.WIDTH(`DATA_W), .DEPTH(FIFO_DEPTH)) i_word_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_data(bus.readdata),
        .in_valid(done), // Word captured at end of transfer [RQ18]
        .in_ready(),
        .out_data(rsp_data),
        .out_valid(rsp_valid),
        .out_ready(rsp_ready)
    );

    // ----------------------------------------------------------------
    // Side-band inputs from the fabric
    // ----------------------------------------------------------------
    // Each copied once so that the outputs come straight from flip-flops;
    // the fabric end drives them on the same clock, so no synchroniser
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_pending <= 1'b0;
        end else begin
            irq_pending <= bus.irq; // [RQ7]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_level <= '0;
        end else begin
            irq_level <= bus.irq_prio; // [RQ7]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            packet_end <= 1'b0;
        end else begin
            packet_end <= bus.endofpacket; // [RQ8]
        end
    end
endmodule

// >>> src/mport_defs.svh
// Constants shared by the master port and the fabric end.
// Assumes inclusion by bare name from src/.
`ifndef MPORT_DEFS_SVH
`define MPORT_DEFS_SVH

`define ADDR_W 32
`define DATA_W 32
`define LANES_W 4
`define PRIO_W 6
`define LANES_ALL_ON 4'h0
`define LANES_ALL_OFF 4'hf
`define FIFO_DEPTH 16
`define WAIT_W 8

`endif

// >>> src/mport_pkg.sv
// Types for the master port link; only the master port uses them.
// Assumes mport_defs.svh is on the include path.
`include "mport_defs.svh"

package mport_pkg;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] word_t;
    typedef enum logic [2:0] {
        M_IDLE = 3'h1,
        M_BUSY = 3'h2,
        M_DONE = 3'h4
    } mstate_t;
endpackage

// >>> src/mport_if.sv
// Link between a master port and the interconnect fabric.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
`include "mport_defs.svh"

interface mport_if;
    logic [`ADDR_W-1:0] address;
    logic [`LANES_W-1:0] byteenable_n;
    logic read_n;
    logic write_n;
    logic [`DATA_W-1:0] writedata;
    logic [`DATA_W-1:0] readdata;
    logic waitrequest;
    logic irq;
    logic [`PRIO_W-1:0] irq_prio;
    logic endofpacket;
    logic readdatavalid;
    logic flush;

    modport master (
        output address, byteenable_n, read_n, write_n, writedata, flush,
        input readdata, waitrequest, irq, irq_prio, endofpacket, readdatavalid
    );
    modport fabric (
        input address, byteenable_n, read_n, write_n, writedata, flush,
        output readdata, waitrequest, irq, irq_prio, endofpacket, readdatavalid
    );
endinterface

// >>> src/word_fifo.sv
// Parameterised FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps

module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk, // System clock
    input wire logic reset_n, // Synchronous reset
    input wire logic [WIDTH-1:0] in_data, // Write word
    input wire logic in_valid, // Write offered
    output logic in_ready, // Room available
    output logic [WIDTH-1:0] out_data, // Head word
    output logic out_valid, // Head valid
    input wire logic out_ready // Head taken
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> src/bus_fabric_end.sv
// Fabric end of the master link: answers reads with programmable stall.
// Assumes the master holds its outputs while stalled. [RQ14]
`timescale 1ns/1ps
`include "mport_defs.svh"

module bus_fabric_end #(
    parameter int WAIT_W = `WAIT_W
) (
    input wire logic clk, // System clock [RQ1]
    input wire logic reset_n, // Synchronous reset
    mport_if.fabric bus, // Link to the master
    input wire logic [WAIT_W-1:0] wait_cycles, // Stall cycles per read
    output logic [`ADDR_W-1:0] slave_addr, // Address of current read
    output logic slave_rd, // Read in progress
    input wire logic [`DATA_W-1:0] slave_data, // Data from the slave
    input wire logic irq_in, // Slave interrupt
    input wire logic [`PRIO_W-1:0] irq_prio_in, // Slave priority
    input wire logic eop_in // Slave packet end
);
    logic [WAIT_W-1:0] wcnt;
    logic rd;

    assign rd = !bus.read_n;
    assign slave_addr = bus.address;
    assign slave_rd = rd;

    // Count stall cycles within each read; reload once it ends
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wcnt <= '0;
        end else if (rd && wcnt < wait_cycles) begin
            wcnt <= wcnt + 1'b1;
        end else begin
            wcnt <= '0;
        end
    end

    // Stall raised combinationally in the first cycle [RQ13] [RQ6] [RQ18]
    // A less-than compare keeps a mid-read change of wait_cycles from
    // running the counter past its target and stalling for a full wrap
    assign bus.waitrequest = rd && (wcnt < wait_cycles);
    assign bus.readdata = slave_data; // Zero-latency return
    assign bus.readdatavalid = 1'b0; // [RQ9]

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bus.irq <= 1'b0;
            bus.irq_prio <= '0;
            bus.endofpacket <= 1'b0;
        end else begin
            bus.irq <= irq_in; // [RQ7]
            bus.irq_prio <= irq_prio_in;
            bus.endofpacket <= eop_in; // [RQ8]
        end
    end
endmodule

// >>> verif/mport_asserts.sv
// Checker on the master link signals.
// Assumes the bench instantiates it beside the interface.
`timescale 1ns/1ps
`include "mport_defs.svh"
module mport_asserts (
    input wire logic clk, // Clock
    input wire logic reset_n, // Sync reset
    input wire logic [`ADDR_W-1:0] address, // Byte address
    input wire logic [`LANES_W-1:0] byteenable_n, // Lanes
    input wire logic read_n, // Read strobe
    input wire logic write_n, // Write strobe
    input wire logic flush, // Cancel
    input wire logic waitrequest // Stall
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_stalled;
        !read_n && waitrequest;
    endsequence
    property p_hold;
        s_stalled |=> !read_n && $stable(address) && $stable(byteenable_n);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved in stall");
    property p_lanes; !read_n |-> byteenable_n == `LANES_ALL_ON; endproperty
    a_lanes: assert property (p_lanes) else $error("lanes off in read");
    property p_idle; read_n |-> byteenable_n == `LANES_ALL_OFF; endproperty
    a_idle: assert property (p_idle) else $error("lanes on when idle");
    property p_drop; read_n |-> address == '0; endproperty
    a_drop: assert property (p_drop) else $error("address kept idle");
    property p_nowr; write_n; endproperty
    a_nowr: assert property (p_nowr) else $error("write strobe active");
    property p_noflush; !flush; endproperty
    a_noflush: assert property (p_noflush) else $error("cancel raised");
    property p_wreq; waitrequest |-> !read_n; endproperty
    a_wreq: assert property (p_wreq) else $error("stall with no read");
    property p_wmax; waitrequest [*7] |=> !waitrequest; endproperty
    a_wmax: assert property (p_wmax) else $error("stall too long");
endmodule

// >>> verif/bus_master_port_read_tb.sv
// Bench joining master port and fabric end.
// Assumes the design files under src/.
`timescale 1ns/1ps
`include "mport_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module bus_master_port_read_tb;
    logic clk = 0, reset_n = 0, req_valid = 0, rsp_ready = 0, hold = 0;
    logic req_ready, rsp_valid, irq_pending, packet_end, slave_rd, irq_in, eop_in;
    logic [31:0] req_addr, rsp_data, slave_addr, slave_data, rnd = 32'h5d0d53b4;
    logic [5:0] irq_level, irq_prio_in;
    logic [7:0] wait_cycles;
    logic [31:0] q[$];
    logic [31:0] pace = 32'h5d0d53b4;
    int error_cnt = 0, n_compared = 0, w, n;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] exp_word(input logic [31:0] a);
        return ~{a[7:0], a[31:8]};
    endfunction
    always #25 clk = ~clk;
    assign slave_data = exp_word(slave_addr);
    mport_if i_mport_if();
    bus_master_port i_bus_master_port(.clk, .reset_n, .bus(i_mport_if.master),
        .req_addr, .req_valid, .req_ready, .rsp_data, .rsp_valid, .rsp_ready,
        .irq_pending, .irq_level, .packet_end);
    bus_fabric_end i_bus_fabric_end(.clk, .reset_n, .bus(i_mport_if.fabric),
        .wait_cycles, .slave_addr, .slave_rd, .slave_data, .irq_in, .irq_prio_in, .eop_in);
    mport_asserts i_mport_asserts(.clk, .reset_n, .address(i_mport_if.address),
        .byteenable_n(i_mport_if.byteenable_n), .read_n(i_mport_if.read_n),
        .write_n(i_mport_if.write_n), .flush(i_mport_if.flush),
        .waitrequest(i_mport_if.waitrequest));
    // ----------------------------------------
    // Consumer: random pacing, checks each word
    // ----------------------------------------
    always @(negedge clk) begin
        rsp_ready = !hold && pace[4];
        pace = lfsr(pace);
        if (rsp_valid === 1'b1 && rsp_ready) begin
            `CHK(rsp_data, exp_word(q.pop_front()))
        end
    end
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Leaves the request up so back-to-back calls never toggle it
    task automatic put(input logic [31:0] a);
        int k;
        req_addr = a;
        req_valid = 1;
        for (k = 0; k < 200; k++) begin
            #1;
            if (req_ready === 1'b1) break;
            @(negedge clk);
        end
        if (k == 200) begin error_cnt++; wrap_up(); end
        q.push_back(a);
        @(negedge clk);
        rnd = lfsr(rnd);
    endtask
    initial begin
        req_addr = 0; wait_cycles = 0; irq_in = 0; irq_prio_in = 0; eop_in = 0;
        repeat (20) @(negedge clk);
        reset_n = 1;
        @(negedge clk);
        for (w = 0; w < 8; w++) begin
            wait_cycles = 8'(w);
            put(rnd);
            req_valid = 0;
            for (n = 0; n < 50 && i_mport_if.read_n === 1'b0; n++) @(negedge clk);
            `CHK(n, w + 1)
        end
        for (w = 0; w < 4; w++) begin
            irq_in = rnd[0]; irq_prio_in = rnd[6:1]; eop_in = rnd[7];
            rnd = lfsr(rnd);
            repeat (2) @(negedge clk);
            `CHK(irq_pending, irq_in)
            `CHK(irq_level, irq_prio_in)
            `CHK(packet_end, eop_in)
        end
        for (n = 0; n < 200 && q.size() != 0; n++) @(negedge clk);
        `CHK(q.size(), 0)
        hold = 1;
        wait_cycles = 8'h03;
        repeat (16) put(rnd);
        repeat (12) @(negedge clk);
        #1;
        `CHK(req_ready, 1'b0)
        hold = 0;
        for (w = 0; w < 60; w++) begin
            if (w == 30) wait_cycles = {5'h00, rnd[2:0]};
            put(rnd);
        end
        req_valid = 0;
        for (n = 0; n < 800 && q.size() != 0; n++) @(negedge clk);
        `CHK(q.size(), 0)
        wrap_up();
    end
endmodule
